// ---- rtl/dic_cfg.svh ----
// register map, field positions, reset values and timing of the interrupt controller
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define DIC_OFS_MASK        8'h00
`define DIC_OFS_CTRL        8'h04
`define DIC_OFS_FC          8'h08
`define DIC_OFS_CMD         8'h0C
`define DIC_OFS_STAT        8'h10
`define DIC_OFS_SVC         8'h14

// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define DIC_CTL_PROG_EDGE   0
`define DIC_CTL_RX_EDGE     1
`define DIC_CTL_TX_EDGE     2
`define DIC_CTL_NEST        3
`define DIC_CTL_ALT_MODE    4
`define DIC_CTL_CTX_CLR     5
`define DIC_CTL_XTAL_OFF    6
`define DIC_CTL_FLAG_OUT    7

// --------------------------------------------------------------
// command register fields, force/clear split
// --------------------------------------------------------------
`define DIC_CMD_ENA         0
`define DIC_CMD_DIS         1
`define DIC_CMD_IDLE        2
`define DIC_CMD_SLOW        3
`define DIC_CMD_DIV_LO      4
`define DIC_CMD_DORMANT     6
`define DIC_FC_CLR_LO       16

// --------------------------------------------------------------
// reset values, vectors, sizes
// --------------------------------------------------------------
`define DIC_MASK_RST        11'h000
`define DIC_CTRL_RST        8'h00
`define DIC_VEC_RESET       14'h0000
`define DIC_VEC_PD          14'h002C
`define DIC_SLOW_BASE       14'h0010
`define DIC_NSRC            11
`define DIC_STACK_LEVELS    12

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define DIC_CLK_NS          20
`define DIC_INCLK_NS        40
`define DIC_WAKE_RUN_INCLK  200
`define DIC_WAKE_XTAL_INCLK 4096

`endif

// ---- rtl/dic_pkg.sv ----
// types shared by the interrupt controller
package dic_pkg;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_IDLE,
		ST_SLOW,
		ST_DORMANT,
		ST_WAKE
	} dic_pm_t;

	typedef logic [13:0] dic_vec_t;

endpackage

// ---- rtl/dic_top.sv ----
// prioritising interrupt controller with idle and power-down control, AXI4-Lite registers
//
// How it works
// - eleven sources plus reset, fixed priority, one service pulse to the sequencer
// - vectors: reset 0000, power-down 002C, others 0004 upward by four, timer 0028
// - pending requests ANDed with the mask; lowest index survivor is taken
// - power-down and reset ignore the mask register
// - programmable pin and both alternate frame requests pick edge or level by control bits
// - level pins always level; edge pin always edge, forceable and clearable
// - nesting bit: higher priority preempts, else wait until no handler active
// - no interrupt taken the cycle after a mask register write
// - write-only force/clear register sets or clears pending requests, reads zero
// - each take pushes in-service state onto a twelve-level hardware stack
// - global enable/disable commands gate every interrupt, DMA grants untouched
// - global enable is set by reset
// - alternate mode: frame pins become requests on port-1 vectors, data pins flags
// - running clock: resume 200 input-clock cycles after leaving power-down
// - crystal stopped: wait about 4096 input-clock cycles before resuming
// - power-down starts from the request pin or the software force bit
// - power-down first raises its nonmaskable edge interrupt; handler enters dormant
// - context bit picks resume in place or restart from vector 0000
// - reset ends power-down
// - power-down acknowledge shows the dormant state
// - idle stalls until an unmasked request, then resumes, and serves it if global enable is set
// - DMA requests still granted while idle
// - slow idle divides by 16/32/64/128; wake-up takes at most that many cycles
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dic_cfg.svh"

module dic_top #(
	parameter int WAKE_XTAL_CYC = `DIC_WAKE_XTAL_INCLK * `DIC_INCLK_NS / `DIC_CLK_NS,
	parameter int STACK_DEPTH   = `DIC_STACK_LEVELS
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         programmable_request_pin_n,
	input  wire logic         level_request_pin_a_n,
	input  wire logic         level_request_pin_b_n,
	input  wire logic         edge_request_pin_n,
	input  wire logic         alt_receive_frame_request_n,
	input  wire logic         alt_transmit_frame_request_n,
	input  wire logic         alt_flag_input,
	input  wire logic         power_down_request_pin_n,
	input  wire logic         sp0_tx_irq,
	input  wire logic         sp0_rx_irq,
	input  wire logic         sp1_tx_irq,
	input  wire logic         sp1_rx_irq,
	input  wire logic         byte_dma_irq,
	input  wire logic         timer_irq,
	input  wire logic         handler_done,
	input  wire logic         dma_req,
	output logic              service_req,
	output dic_pkg::dic_vec_t service_vector,
	output logic              ctx_clear,
	output logic              run_enable,
	output logic              pd_ack,
	output logic              dma_grant,
	output logic              alt_flag_output
);
	import dic_pkg::*;

	localparam int NSRC = `DIC_NSRC;
	localparam logic [13:0] WAKE_RUN_CYC =
		14'(`DIC_WAKE_RUN_INCLK * `DIC_INCLK_NS / `DIC_CLK_NS);
	localparam logic [13:0] WAKE_XTAL_W = 14'(WAKE_XTAL_CYC);
	localparam logic [3:0]  DEPTH_W = 4'(STACK_DEPTH);

	if (STACK_DEPTH < 1 || STACK_DEPTH > 15 || WAKE_XTAL_CYC < 1 || WAKE_XTAL_CYC > 16383) begin : g_chk
		$error("dic_top: parameter out of range");
	end

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic            aw_got_r, w_got_r;
	logic [7:0]      awaddr_r;
	logic [31:0]     wd_r, rdata_r;
	logic [1:0]      bresp_r, rresp_r;
	logic [NSRC-1:0] mask_r, latch_r, active_r;
	logic [7:0]      ctl_r;
	logic            gie_r, mblock_r;
	logic [4:0]      prev_r;
	logic [3:0]      depth_r;
	logic [NSRC-1:0] stk_r [STACK_DEPTH];
	dic_pm_t         pm_r, pm_nxt;
	logic [13:0]     cnt_r, cnt_nxt;
	logic [1:0]      div_r;
	logic            svc_r, ctx_r, run_r, pdack_r, grant_r;
	dic_vec_t        vec_r;

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	wire        do_wr    = aw_got_r & w_got_r & ~bvalid_r;
	wire [7:0]  wa_w     = {awaddr_r[7:2], 2'b00};
	wire [7:0]  ra_w     = {s_axi_araddr[7:2], 2'b00};
	wire        ws_mask  = wa_w == `DIC_OFS_MASK;
	wire        ws_ctrl  = wa_w == `DIC_OFS_CTRL;
	wire        ws_fc    = wa_w == `DIC_OFS_FC;
	wire        ws_cmd   = wa_w == `DIC_OFS_CMD;
	wire        ws_ro    = (wa_w == `DIC_OFS_STAT) | (wa_w == `DIC_OFS_SVC);
	wire        ws_ok    = ws_mask | ws_ctrl | ws_fc | ws_cmd | ws_ro;
	wire        wr_mask  = do_wr & ws_mask;
	wire        wr_ctrl  = do_wr & ws_ctrl;
	wire        wr_fc    = do_wr & ws_fc;
	wire        wr_cmd   = do_wr & ws_cmd;
	wire [31:0] wstrb_x  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	wire        rs_ok    = (ra_w == `DIC_OFS_MASK) | (ra_w == `DIC_OFS_CTRL)
		| (ra_w == `DIC_OFS_FC) | (ra_w == `DIC_OFS_CMD)
		| (ra_w == `DIC_OFS_STAT) | (ra_w == `DIC_OFS_SVC);

	// --------------------------------------------------------------
	// request sources
	// --------------------------------------------------------------
	wire [4:0]  pins_n   = {alt_transmit_frame_request_n, alt_receive_frame_request_n,
		edge_request_pin_n, programmable_request_pin_n, power_down_request_pin_n};
	wire [4:0]  fall_w   = prev_r & ~pins_n;
	wire        alt_w    = ctl_r[`DIC_CTL_ALT_MODE];
	wire        pg_edge  = ctl_r[`DIC_CTL_PROG_EDGE];
	wire        rx_edge  = ctl_r[`DIC_CTL_RX_EDGE];
	wire        tx_edge  = ctl_r[`DIC_CTL_TX_EDGE];
	wire        pd_ev    = fall_w[0] & (pm_r != ST_DORMANT);
	wire        rx1_ev   = alt_w ? (rx_edge & fall_w[3]) : sp1_rx_irq;
	wire        tx1_ev   = alt_w ? (tx_edge & fall_w[4]) : sp1_tx_irq;
	wire        rx1_lv   = alt_w & ~rx_edge & ~alt_receive_frame_request_n;
	wire        tx1_lv   = alt_w & ~tx_edge & ~alt_transmit_frame_request_n;
	wire        pg_lv    = ~pg_edge & ~programmable_request_pin_n;
	wire [NSRC-1:0] frc_w = wr_fc ? wd_r[NSRC-1:0] : '0;
	wire [NSRC-1:0] fcl_w = wr_fc ? wd_r[`DIC_FC_CLR_LO +: NSRC] : '0;
	wire [NSRC-1:0] set_w = {timer_irq, rx1_ev, tx1_ev, byte_dma_irq, fall_w[2], sp0_rx_irq,
		sp0_tx_irq, 2'b00, pg_edge & fall_w[1], pd_ev} | frc_w;
	wire [NSRC-1:0] lvl_w = {1'b0, rx1_lv, tx1_lv, 4'h0, ~level_request_pin_a_n,
		~level_request_pin_b_n, pg_lv, 1'b0};
	wire [NSRC-1:0] pend_w = latch_r | lvl_w;
	wire [NSRC-1:0] cand_w = pend_w & {mask_r[NSRC-1:1], 1'b1};

	// --------------------------------------------------------------
	// arbitration
	// --------------------------------------------------------------
	logic [NSRC-1:0] allow_w, ok_w, latch_nxt;
	logic [3:0]      sel_idx;
	logic            any_ok;

	for (genvar g = 0; g < NSRC; g++) begin : g_src
		localparam logic [NSRC-1:0] UPTO = NSRC'((1 << (g + 1)) - 1);
		assign allow_w[g] = ctl_r[`DIC_CTL_NEST] ? ~|(active_r & UPTO) : ~|active_r;
		assign ok_w[g] = cand_w[g] & allow_w[g];
	end

	always_comb begin
		sel_idx = 4'h0;
		any_ok  = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (ok_w[i]) begin
				sel_idx = 4'(i);
				any_ok  = 1'b1;
			end
		end
	end

	wire        full_w   = depth_r == DEPTH_W;
	wire        take_w   = (pm_r == ST_RUN) & gie_r & ~mblock_r & any_ok
		& ~handler_done & ~full_w;
	wire [NSRC-1:0] take_oh = take_w ? (NSRC'(1) << sel_idx) : '0;
	wire        pop_w    = handler_done & (depth_r != 4'h0);
	wire        restart_w = (pm_r == ST_WAKE) & (cnt_r == 14'h0000) & ctl_r[`DIC_CTL_CTX_CLR];
	wire [NSRC-1:0] clr_w = fcl_w | take_oh;
	wire [13:0] vec_w    = (sel_idx == 4'h0) ? `DIC_VEC_PD : {8'h00, sel_idx, 2'b00};
	assign latch_nxt = set_w | (latch_r & ~clr_w);

	// --------------------------------------------------------------
	// command decode
	// --------------------------------------------------------------
	wire        c_ena    = wr_cmd & wd_r[`DIC_CMD_ENA];
	wire        c_dis    = wr_cmd & wd_r[`DIC_CMD_DIS];
	wire        c_idle   = wr_cmd & wd_r[`DIC_CMD_IDLE];
	wire        c_slow   = wd_r[`DIC_CMD_SLOW];
	wire [1:0]  c_div    = wd_r[`DIC_CMD_DIV_LO +: 2];
	wire        c_dorm   = wr_cmd & wd_r[`DIC_CMD_DORMANT];
	wire [13:0] slow_n   = `DIC_SLOW_BASE << div_r;

	// --------------------------------------------------------------
	// power management
	// --------------------------------------------------------------
	always_comb begin
		pm_nxt  = pm_r;
		cnt_nxt = (cnt_r == 14'h0000) ? 14'h0000 : cnt_r - 14'h0001;
		case (pm_r)
			ST_RUN: begin
				if (c_dorm) begin
					pm_nxt = ST_DORMANT;
				end else if (c_idle && c_slow) begin
					pm_nxt  = ST_SLOW;
					cnt_nxt = (`DIC_SLOW_BASE << c_div) - 14'h0001;
				end else if (c_idle) begin
					pm_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (|cand_w) pm_nxt = ST_RUN;
			end
			ST_SLOW: begin
				if (cnt_r == 14'h0000) begin
					cnt_nxt = slow_n - 14'h0001;
					if (|cand_w) pm_nxt = ST_RUN;
				end
			end
			ST_DORMANT: begin
				if (fall_w[0]) begin
					pm_nxt  = ST_WAKE;
					cnt_nxt = ctl_r[`DIC_CTL_XTAL_OFF] ? WAKE_XTAL_W - 14'h0001
						: WAKE_RUN_CYC - 14'h0001;
				end
			end
			ST_WAKE: begin
				if (cnt_r == 14'h0000) pm_nxt = ST_RUN;
			end
			default: pm_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pm_r  <= ST_RUN;
			cnt_r <= 14'h0000;
			div_r <= 2'b00;
		end else begin
			pm_r  <= pm_nxt;
			cnt_r <= cnt_nxt;
			if (pm_r == ST_RUN && c_idle) div_r <= c_div;
		end
	end

	// --------------------------------------------------------------
	// controller registers
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r   <= `DIC_MASK_RST;
			ctl_r    <= `DIC_CTRL_RST;
			gie_r    <= 1'b1;
			mblock_r <= 1'b0;
			latch_r  <= '0;
			prev_r   <= 5'h1F;
		end else begin
			prev_r   <= pins_n;
			mblock_r <= wr_mask;
			if (restart_w) begin
				mask_r  <= `DIC_MASK_RST;
				gie_r   <= 1'b1;
				latch_r <= '0;
			end else begin
				if (wr_mask) mask_r <= {wd_r[NSRC-1:1], 1'b0};
				gie_r   <= c_dis ? 1'b0 : (c_ena ? 1'b1 : gie_r);
				latch_r <= latch_nxt;
			end
			if (wr_ctrl) ctl_r <= wd_r[7:0];
		end
	end

	// --------------------------------------------------------------
	// hardware stack of in-service state
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_r <= '0;
			depth_r  <= 4'h0;
		end else if (restart_w) begin
			active_r <= '0;
			depth_r  <= 4'h0;
		end else if (pop_w) begin
			active_r <= stk_r[depth_r - 4'h1];
			depth_r  <= depth_r - 4'h1;
		end else if (take_w) begin
			active_r <= active_r | take_oh;
			depth_r  <= depth_r + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (take_w) stk_r[depth_r] <= active_r;
	end

	// --------------------------------------------------------------
	// sequencer and pin outputs
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			svc_r   <= 1'b0;
			ctx_r   <= 1'b0;
			vec_r   <= `DIC_VEC_RESET;
			run_r   <= 1'b0;
			pdack_r <= 1'b0;
			grant_r <= 1'b0;
		end else begin
			svc_r   <= take_w | restart_w;
			ctx_r   <= restart_w;
			if (restart_w) vec_r <= `DIC_VEC_RESET;
			else if (take_w) vec_r <= vec_w;
			run_r   <= pm_nxt == ST_RUN;
			pdack_r <= pm_nxt == ST_DORMANT;
			grant_r <= dma_req & (pm_r != ST_DORMANT);
		end
	end

	assign service_req     = svc_r;
	assign service_vector  = vec_r;
	assign ctx_clear       = ctx_r;
	assign run_enable      = run_r;
	assign pd_ack          = pdack_r;
	assign dma_grant       = grant_r;
	assign alt_flag_output = ctl_r[`DIC_CTL_FLAG_OUT];

	// --------------------------------------------------------------
	// AXI4-Lite slave
	// --------------------------------------------------------------
	wire [31:0] stat_w = {11'h000, alt_flag_input, depth_r, pdack_r, 3'(pm_r),
		gie_r, pend_w};
	wire [31:0] svc_w  = {2'b00, vec_r, 5'h00, active_r};
	wire [31:0] rmux_w =
		(ra_w == `DIC_OFS_MASK) ? {21'h000000, mask_r} :
		(ra_w == `DIC_OFS_CTRL) ? {24'h000000, ctl_r} :
		(ra_w == `DIC_OFS_STAT) ? stat_w :
		(ra_w == `DIC_OFS_SVC)  ? svc_w : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wd_r      <= 32'h00000000;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'b00;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awaddr_r  <= s_axi_awaddr;
				aw_got_r  <= 1'b1;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r) begin
				wd_r     <= s_axi_wdata & wstrb_x;
				w_got_r  <= 1'b1;
				wready_r <= 1'b0;
			end
			if (do_wr) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= ws_ok ? 2'b00 : 2'b10;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= 2'b00;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rmux_w;
			rresp_r   <= rs_ok ? 2'b00 : 2'b10;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_vec_map;
		svc_r && !ctx_r |-> vec_r == (($past(sel_idx) == 4'h0) ? 14'h002C
			: {8'h00, $past(sel_idx), 2'b00});
	endproperty
	a_vec_map: assert property (p_vec_map) else $error("wrong vector");

	property p_masked;
		take_w |-> sel_idx == 4'h0 || mask_r[sel_idx];
	endproperty
	a_masked: assert property (p_masked) else $error("masked source taken");

	property p_mask_block;
		wr_mask |-> ##2 !svc_r || ctx_r;
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("take after mask write");

	property p_gie;
		!gie_r |=> !svc_r || ctx_r;
	endproperty
	a_gie: assert property (p_gie) else $error("take while disabled");

	property p_gie_rst;
		disable iff (1'b0) !aresetn |=> gie_r;
	endproperty
	a_gie_rst: assert property (p_gie_rst) else $error("enable not set by reset");

	property p_nest;
		!ctl_r[`DIC_CTL_NEST] && (|active_r) |=> !svc_r || ctx_r;
	endproperty
	a_nest: assert property (p_nest) else $error("preempt without nesting");

	property p_edge_once;
		take_w && sel_idx == 4'h6 && !set_w[6] |=> !latch_r[6];
	endproperty
	a_edge_once: assert property (p_edge_once) else $error("edge latch kept");

	sequence s_leave_pd;
		pm_r == ST_DORMANT && fall_w[0] && !ctl_r[`DIC_CTL_XTAL_OFF];
	endsequence
	property p_wake_fast;
		s_leave_pd |=> !run_r [*8] ##[1:400] run_r;
	endproperty
	a_wake_fast: assert property (p_wake_fast) else $error("wake time wrong");

	property p_idle_wake;
		pm_r == ST_IDLE && (|cand_w) |=> run_r;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

	property p_dma;
		dma_req && pm_r != ST_DORMANT |=> grant_r;
	endproperty
	a_dma: assert property (p_dma) else $error("DMA not granted");

	property p_pdack;
		c_dorm && pm_r == ST_RUN |=> pdack_r && !run_r;
	endproperty
	a_pdack: assert property (p_pdack) else $error("no power-down acknowledge");

endmodule // dic_top

// ---- tb/dic_seq_model.sv ----
// sequencer stand-in: returns from a handler a fixed delay after the latest service pulse; each pulse restarts the delay
`timescale 1ns/1ps
module dic_seq_model #(
	parameter int DLY = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              service_req,
	input  wire dic_pkg::dic_vec_t service_vector,
	output logic                   handler_done,
	output logic [7:0]             n_svc
);
	import dic_pkg::*;
	int cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			handler_done <= 1'b0;
			n_svc <= 8'h00;
		end else begin
			handler_done <= (cnt == 1);
			if (service_req) begin
				cnt <= DLY;
				n_svc <= n_svc + 8'h01;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // dic_seq_model

// ---- tb/tb.sv ----
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
module tb;
	import dic_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr, nsvc, n0;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r, b;
	logic        prog_n, lva_n, lvb_n, edg_n, pd_n, arx_n, dma_req;
	logic [5:0]  ir;
	logic        hdone, sreq, run_en, pd_ack, dgnt, ctx, afo;
	dic_vec_t    svec;
	int          n_errors = 0, total_checks = 0, cyc = 0;

	dic_top #(.WAKE_XTAL_CYC(20)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.programmable_request_pin_n(prog_n), .level_request_pin_a_n(lva_n),
		.level_request_pin_b_n(lvb_n), .edge_request_pin_n(edg_n),
		.alt_receive_frame_request_n(arx_n), .alt_transmit_frame_request_n(1'b1),
		.alt_flag_input(1'b0), .power_down_request_pin_n(pd_n),
		.sp0_tx_irq(ir[0]), .sp0_rx_irq(ir[1]), .byte_dma_irq(ir[2]), .sp1_tx_irq(ir[3]),
		.sp1_rx_irq(ir[4]), .timer_irq(ir[5]), .handler_done(hdone), .dma_req(dma_req),
		.service_req(sreq), .service_vector(svec), .ctx_clear(ctx), .run_enable(run_en),
		.pd_ack(pd_ack), .dma_grant(dgnt), .alt_flag_output(afo));
	dic_seq_model #(.DLY(8)) seq_u (.aclk(aclk), .aresetn(aresetn), .service_req(sreq),
		.service_vector(svec), .handler_done(hdone), .n_svc(nsvc));

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		bit ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		b = bresp;
		bready <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task wait_svc(input dic_vec_t v);
		int i;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (!sreq && i < 60);
		chk({sreq, svec}, {1'b1, v});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd(8'h10);
		chk(d[11], 1);
		rd(8'h08);
		chk(d, 0);
		chk(r, 2'h0);
		rd(8'h18);
		chk(r, 2'h2);
		wr(8'h08, 32'h0);
		chk(b, 2'h0);
		wr(8'h18, 32'h0);
		chk(b, 2'h2);
	endtask
	task t_prio;
		wr(8'h00, 32'h0000000E);
		prog_n <= 0;
		lvb_n <= 0;
		lva_n <= 0;
		wait_svc(14'h0004);
		prog_n <= 1;
		wait_svc(14'h0008);
		lvb_n <= 1;
		wait_svc(14'h000C);
		lva_n <= 1;
	endtask
	task t_src;
		byte idx[6] = '{4, 5, 7, 8, 9, 10};
		wr(8'h00, 32'h000007FE);
		for (int k = 0; k < 6; k++) begin
			ir[k] <= 1;
			@(posedge aclk);
			ir[k] <= 0;
			wait_svc({idx[k], 2'b00});
		end
		repeat (30) @(posedge aclk);
		n0 = nsvc;
		edg_n <= 0;
		repeat (2) @(posedge aclk);
		edg_n <= 1;
		wait_svc(14'h0018);
		repeat (40) @(posedge aclk);
		chk(nsvc - n0, 1);
	endtask
	task t_pd;
		wr(8'h00, 32'h0);
		n0 = nsvc;
		lva_n <= 0;
		repeat (30) @(posedge aclk);
		chk(nsvc, n0);
		lva_n <= 1;
		pd_n <= 0;
		wait_svc(14'h002C);
		pd_n <= 1;
		wr(8'h08, 32'h1);
		wait_svc(14'h002C);
	endtask
	task t_idle;
		wr(8'h0C, 32'h2);
		wr(8'h00, 32'h400);
		wr(8'h0C, 32'h4);
		n0 = nsvc;
		dma_req <= 1;
		repeat (3) @(posedge aclk);
		chk({run_en, dgnt}, 2'b01);
		wr(8'h08, 32'h400);
		repeat (10) @(posedge aclk);
		chk({run_en, nsvc}, {1'b1, n0});
		dma_req <= 0;
		wr(8'h0C, 32'h1);
		wait_svc(14'h0028);
	endtask
	task t_dormant;
		int i;
		wr(8'h0C, 32'h40);
		repeat (2) @(posedge aclk);
		chk({pd_ack, run_en}, 2'b10);
		pd_n <= 0;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (!run_en && i < 500);
		chk(i <= 402, 1);
		pd_n <= 1;
	endtask
	task t_ctx;
		int i;
		wr(8'h04, 32'hE0);
		chk(afo, 1);
		wr(8'h0C, 32'h40);
		pd_n <= 0;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (!sreq && i < 60);
		chk(i >= 20 && i <= 22, 1);
		chk({ctx, svec}, {1'b1, 14'h0000});
		pd_n <= 1;
		rd(8'h00);
		chk(d, 0);
	endtask
	task t_rst;
		wr(8'h0C, 32'h40);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		chk({pd_ack, run_en, afo}, 3'b010);
	endtask
	task t_misc;
		wr(8'h04, 32'h19);
		wr(8'h00, 32'h602);
		wr(8'h08, 32'h40);
		rd(8'h10);
		chk(d[6], 1);
		wr(8'h08, 32'h00400000);
		rd(8'h10);
		chk(d[6], 0);
		wr(8'h0C, 32'hC);
		arx_n <= 0;
		repeat (4) @(posedge aclk);
		chk(run_en, 0);
		wait_svc(14'h0024);
		arx_n <= 1;
		repeat (12) @(posedge aclk);
		n0 = nsvc;
		ir[5] <= 1;
		@(posedge aclk);
		ir[5] <= 0;
		wait_svc(14'h0028);
		prog_n <= 0;
		wait_svc(14'h0004);
		repeat (30) @(posedge aclk);
		prog_n <= 1;
		chk(nsvc - n0, 2);
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report;
		end
	end
	initial begin
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready, dma_req} = '0;
		{awaddr, araddr, wdata, ir} = '0;
		wstrb = 4'hF;
		{prog_n, lva_n, lvb_n, edg_n, pd_n, arx_n} = 6'h3F;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_prio;
		t_src;
		t_pd;
		t_idle;
		t_dormant;
		t_ctx;
		t_rst;
		t_misc;
		final_report;
	end
endmodule // tb
